// File: src/rspg_top.sv
// Reset sequencer and sleep power gating with an Avalon-MM register slave.
// Assumes fuses are static straps, TAP signals run on mclk, analog detector
// outputs and the reset pin are asynchronous.
`timescale 1ns/10ps
module rspg_top #(
    parameter int unsigned WDT_TOUT_CYC = rspg_pkg::WDT_TOUT_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [rspg_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [rspg_pkg::DATA_W-1:0] avs_writedata,
    output logic [rspg_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Reset sources
    input wire logic poweron_low,
    input wire logic brownout_low,
    input wire logic ext_reset_n,
    input wire logic jtag_reset_reg,
    // Fuses
    input wire logic brownout_detect_fuse,
    input wire logic brownout_level_fuse,
    input wire logic onchip_debug_fuse,
    input wire logic jtag_port_fuse,
    input wire logic [3:0] clock_select_fuses,
    input wire logic [1:0] startup_time_fuses,
    // Wake-up and converter
    input wire logic wake_a,
    input wire logic adc_conv_done,
    // TAP
    input wire logic tap_shifting,
    input wire logic tap_tdo,
    output logic tdo_o,
    output logic tdo_oe,
    // Resets out
    output logic sys_reset,
    output logic io_port_reset,
    // Power gating
    output logic adc_power,
    output logic adc_ext_conv,
    output logic ac_power,
    output logic bandgap_en,
    output logic brownout_power,
    output logic brownout_level,
    output logic wdt_run,
    output logic in_buf_en,
    output logic main_clk_en,
    output logic jtag_en
);
    // ============
    // Declarations
    logic [1:0] por_sync_ff;
    logic [1:0] bod_sync_ff;
    logic [1:0] wake_sync_ff;
    rspg_pkg::rspg_rst_e state_ff;
    rspg_pkg::rspg_rst_e nxt_state;
    logic [rspg_pkg::CNT_W-1:0] dly_cnt_ff;
    logic [rspg_pkg::CNT_W-1:0] nxt_dly_cnt;
    logic [rspg_pkg::CNT_W-1:0] tout_sel_ff;
    logic sys_reset_ff;
    logic io_port_reset_ff;
    logic [rspg_pkg::WDT_W-1:0] wdt_cnt_ff;
    logic wdt_pulse_ff;
    logic [rspg_pkg::CTRL_W-1:0] ctrl_ff;
    logic [rspg_pkg::FLAG_W-1:0] flag_ff;
    logic sleeping_ff;
    logic adc_en_d_ff;
    logic adc_ext_conv_ff;
    logic [rspg_pkg::DATA_W-1:0] rdata_ff;
    logic wait_ff;
    logic tdo_o_ff;
    logic tdo_oe_ff;
    logic adc_power_ff;
    logic ac_power_ff;
    logic bandgap_en_ff;
    logic wdt_run_ff;
    logic in_buf_en_ff;
    logic main_clk_en_ff;
    logic jtag_en_ff;
    logic ext_hit;
    logic jtag_hit;
    logic wdt_kick;
    logic bod_power_ff;
    logic bod_level_ff;

    // ============
    // Asynchronous reset sources
    wire bod_act_a = brownout_detect_fuse & brownout_low;
    wire por_set_a = reset | poweron_low;
    wire hard_set_a = por_set_a | bod_act_a;

    // Power-on and brown-out assert at once, release through two flops
    always_ff @(posedge mclk or posedge por_set_a) begin
        if (por_set_a) begin
            por_sync_ff <= 2'b11;
        end else begin
            por_sync_ff <= {por_sync_ff[0], 1'b0};
        end
    end

    always_ff @(posedge mclk or posedge bod_act_a) begin
        if (bod_act_a) begin
            bod_sync_ff <= 2'b11;
        end else begin
            bod_sync_ff <= {bod_sync_ff[0], 1'b0};
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wake_sync_ff <= 2'b00;
        end else begin
            wake_sync_ff <= {wake_sync_ff[0], wake_a};
        end
    end

    // ============
    // Pin and scan-chain sources
    rspg_pin_filter #(
        .MIN_CYC(rspg_pkg::RST_PULSE_CYC),
        .ACT_LOW(1'b1)
    ) u_ext_filter (
        .mclk(mclk),
        .reset(reset),
        .pin_a(ext_reset_n),
        .hit(ext_hit)
    );

    rspg_pin_filter #(
        .MIN_CYC(1),
        .ACT_LOW(1'b0)
    ) u_jtag_filter (
        .mclk(mclk),
        .reset(reset),
        .pin_a(jtag_reset_reg),
        .hit(jtag_hit)
    );

    // ============
    // Reset sequencer
    wire por_s = por_sync_ff[1];
    wire bod_s = bod_sync_ff[1];
    wire src_active = por_s | bod_s | ext_hit | jtag_hit | wdt_pulse_ff;
    wire dly_done = (dly_cnt_ff == tout_sel_ff);

    // Length of the stretch chosen by the clock-select fuses
    wire [rspg_pkg::CNT_W-1:0] tout_pick =
        (clock_select_fuses[1:0] == 2'd0) ? rspg_pkg::TOUT_CYC_0 :
        (clock_select_fuses[1:0] == 2'd1) ? rspg_pkg::TOUT_CYC_1 :
        (clock_select_fuses[1:0] == 2'd2) ? rspg_pkg::TOUT_CYC_2 : rspg_pkg::TOUT_CYC_3;

    always_comb begin
        nxt_state = state_ff;
        nxt_dly_cnt = dly_cnt_ff;
        unique case (state_ff)
            rspg_pkg::RST_HOLD: begin
                nxt_dly_cnt = '0;
                if (!src_active) begin
                    nxt_state = rspg_pkg::RST_COUNT;
                end
            end
            rspg_pkg::RST_COUNT: begin
                nxt_dly_cnt = dly_cnt_ff + 1'b1;
                if (src_active) begin
                    nxt_state = rspg_pkg::RST_HOLD;
                end else if (dly_done) begin
                    nxt_state = rspg_pkg::RST_RUN;
                end
            end
            rspg_pkg::RST_RUN: begin
                if (src_active) begin
                    nxt_state = rspg_pkg::RST_HOLD;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge hard_set_a) begin
        if (hard_set_a) begin
            state_ff <= rspg_pkg::RST_HOLD;
            dly_cnt_ff <= '0;
            sys_reset_ff <= 1'b1;
            io_port_reset_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            dly_cnt_ff <= nxt_dly_cnt;
            sys_reset_ff <= (nxt_state != rspg_pkg::RST_RUN);
            io_port_reset_ff <= (nxt_state == rspg_pkg::RST_HOLD);
        end
    end

    // Fuses are caught by the clock while reset is held
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tout_sel_ff <= rspg_pkg::TOUT_CYC_0;
        end else if (state_ff == rspg_pkg::RST_HOLD) begin
            tout_sel_ff <= tout_pick - 1'b1;
        end
    end

    // ============
    // Watchdog
    localparam logic [rspg_pkg::WDT_W-1:0] WDT_LAST = rspg_pkg::WDT_W'(WDT_TOUT_CYC - 1);
    wire wdt_enable = ctrl_ff[rspg_pkg::CB_WDT_EN];
    wire wdt_expire = wdt_enable & (wdt_cnt_ff == WDT_LAST) & !sys_reset_ff;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wdt_cnt_ff <= '0;
            wdt_pulse_ff <= 1'b0;
        end else begin
            wdt_pulse_ff <= wdt_expire;
            if (!wdt_enable || wdt_kick || wdt_expire || sys_reset_ff) begin
                wdt_cnt_ff <= '0;
            end else begin
                wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
            end
        end
    end

    // ============
    // Register decode
    wire bus_req = avs_read | avs_write;
    wire bus_take = bus_req & ~wait_ff;
    wire bus_wr = bus_take & avs_write;
    wire sel_ctrl = (avs_address == rspg_pkg::OFS_CTRL);
    wire sel_sleep = (avs_address == rspg_pkg::OFS_SLEEP);
    wire sel_status = (avs_address == rspg_pkg::OFS_STATUS);
    wire sel_wdt = (avs_address == rspg_pkg::OFS_WDT);
    wire wr_ctrl = bus_wr & sel_ctrl;
    wire wr_flags = bus_wr & sel_status;
    assign wdt_kick = bus_wr & sel_wdt;
    wire sleep_go = bus_wr & sel_sleep & avs_writedata[0] & ctrl_ff[rspg_pkg::CB_SLP_EN];

    wire [2:0] mode = ctrl_ff[rspg_pkg::CB_MODE_LO +: 3];
    wire adc_enable = ctrl_ff[rspg_pkg::CB_ADC_EN];
    wire ac_enable = ctrl_ff[rspg_pkg::CB_AC_EN];
    wire ac_bandgap = ctrl_ff[rspg_pkg::CB_AC_BG];
    wire jtag_on = jtag_port_fuse & ~ctrl_ff[rspg_pkg::CB_JTAG_OFF];
    wire [rspg_pkg::FLAG_W-1:0] flag_set = {jtag_hit, wdt_pulse_ff, bod_s, ext_hit, por_s};

    wire [rspg_pkg::DATA_W-1:0] status_word = {
        20'h0_0000, sleeping_ff, jtag_en_ff, adc_ext_conv_ff, bandgap_en_ff, 3'h0, flag_ff};

    wire [rspg_pkg::DATA_W-1:0] rd_mux =
        sel_ctrl ? {23'h00_0000, ctrl_ff} :
        sel_sleep ? {31'h0000_0000, sleeping_ff} :
        sel_status ? status_word : rspg_pkg::RDATA_RST;

    // One wait cycle, then one cycle with waitrequest low and data standing
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wait_ff <= 1'b1;
            rdata_ff <= rspg_pkg::RDATA_RST;
        end else begin
            wait_ff <= ~(bus_req & wait_ff);
            if (bus_req & wait_ff) begin
                rdata_ff <= avs_read ? rd_mux : rspg_pkg::RDATA_RST;
            end
        end
    end

    // ============
    // Control, flags and sleep state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_ff <= rspg_pkg::CTRL_RST[rspg_pkg::CTRL_W-1:0];
        end else if (sys_reset_ff) begin
            ctrl_ff <= rspg_pkg::CTRL_RST[rspg_pkg::CTRL_W-1:0];
        end else if (wr_ctrl) begin
            ctrl_ff <= avs_writedata[rspg_pkg::CTRL_W-1:0];
        end
    end

    // Writing zero clears a flag; a cause in the same cycle keeps it set
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flag_ff <= '0;
        end else if (wr_flags) begin
            flag_ff <= (flag_ff & avs_writedata[rspg_pkg::FLAG_W-1:0]) | flag_set;
        end else begin
            flag_ff <= flag_ff | flag_set;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sleeping_ff <= 1'b0;
        end else if (sys_reset_ff || wake_sync_ff[1]) begin
            sleeping_ff <= 1'b0;
        end else if (sleep_go) begin
            sleeping_ff <= 1'b1;
        end
    end

    // ============
    // Power gating
    wire deep_sleep = sleeping_ff & (mode != rspg_pkg::MODE_IDLE) & (mode != rspg_pkg::MODE_ADCNR);
    wire osc_stop = sleeping_ff & ((mode == rspg_pkg::MODE_PDOWN) | (mode == rspg_pkg::MODE_PSAVE));
    wire adc_rise = adc_enable & ~adc_en_d_ff;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            adc_en_d_ff <= 1'b0;
            adc_ext_conv_ff <= 1'b0;
            adc_power_ff <= 1'b0;
            ac_power_ff <= 1'b0;
            bandgap_en_ff <= 1'b0;
            wdt_run_ff <= 1'b0;
            in_buf_en_ff <= 1'b1;
            main_clk_en_ff <= 1'b1;
            jtag_en_ff <= 1'b0;
            tdo_o_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else begin
            adc_en_d_ff <= adc_enable;
            if (adc_rise) begin
                adc_ext_conv_ff <= 1'b1;
            end else if (adc_conv_done) begin
                adc_ext_conv_ff <= 1'b0;
            end
            adc_power_ff <= adc_enable;
            ac_power_ff <= ac_enable & ~deep_sleep;
            bandgap_en_ff <= brownout_detect_fuse | (ac_enable & ac_bandgap) | adc_enable;
            wdt_run_ff <= wdt_enable;
            in_buf_en_ff <= ~deep_sleep;
            main_clk_en_ff <= ~osc_stop | (onchip_debug_fuse & jtag_on);
            jtag_en_ff <= jtag_on;
            tdo_o_ff <= tap_tdo;
            tdo_oe_ff <= jtag_on & tap_shifting;
        end
    end

    // ============
    // Outputs
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign sys_reset = sys_reset_ff;
    assign io_port_reset = io_port_reset_ff;
    assign adc_power = adc_power_ff;
    assign adc_ext_conv = adc_ext_conv_ff;
    assign ac_power = ac_power_ff;
    assign bandgap_en = bandgap_en_ff;
    assign brownout_power = bod_power_ff;
    assign brownout_level = bod_level_ff;
    assign wdt_run = wdt_run_ff;
    assign in_buf_en = in_buf_en_ff;
    assign main_clk_en = main_clk_en_ff;
    assign jtag_en = jtag_en_ff;
    assign tdo_o = tdo_o_ff;
    assign tdo_oe = tdo_oe_ff;

    // ============
    // Brown-out detector power and level follow the fuses in every mode
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bod_power_ff <= 1'b0;
            bod_level_ff <= 1'b0;
        end else begin
            bod_power_ff <= brownout_detect_fuse;
            bod_level_ff <= brownout_level_fuse;
        end
    end
endmodule : rspg_top

// File: include/rspg_pkg.sv
// Constants, types and register map of the reset and sleep power gating block.
// Assumes a single 250 MHz clock and an Avalon-MM slave with byte addresses.
//
// Function
// - Enabled converter stays powered in every sleep mode
// - Converter re-enable makes next conversion extended
// - Deep sleep modes switch comparator off automatically
// - Comparator on bandgap keeps reference on in sleep
// - Fuse-enabled brown-out detector stays on in sleep
// - Reference on only while detector, comparator, converter need
// - Enabled watchdog keeps running in all sleep modes
// - Input buffers off when I/O and converter clocks stop
// - Debug fuse with JTAG on keeps main clock in power-down/save
// - JTAG off by control bit or unprogrammed fuse
// - TDO undriven unless TAP is shifting
// - Reset loads registers, fetch restarts at vector
// - Ports reset asynchronously on power-on and brown-out; other sources need the clock
// - Delay counter stretches reset, length from fuses
// - Reset while supply below power-on threshold
// - Reset pin low past minimum width, spikes filtered
// - Reset on enabled watchdog time-out
// - Reset on enabled brown-out below threshold
// - Reset held while JTAG reset register holds one
// - Watchdog pulse one cycle, count from its fall
// - Power-on drop reasserts reset without delay
package rspg_pkg;
    // ============
    // Bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_SLEEP = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_WDT = 4'hc;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // ============
    // Control register fields
    localparam int CB_ADC_EN = 0;
    localparam int CB_AC_EN = 1;
    localparam int CB_AC_BG = 2;
    localparam int CB_WDT_EN = 3;
    localparam int CB_JTAG_OFF = 4;
    localparam int CB_MODE_LO = 5;
    localparam int CB_SLP_EN = 8;
    localparam int CTRL_W = 9;
    // ============
    // Status register fields
    localparam int SB_FLAG_LO = 0;
    localparam int SB_REF_ON = 8;
    localparam int SB_EXT_CONV = 9;
    localparam int SB_JTAG_EN = 10;
    localparam int SB_SLEEPING = 11;
    localparam int FL_POR = 0;
    localparam int FL_EXT = 1;
    localparam int FL_BOD = 2;
    localparam int FL_WDT = 3;
    localparam int FL_JTAG = 4;
    localparam int FLAG_W = 5;
    // ============
    // Sleep mode codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADCNR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;
    // ============
    // Timing
    localparam int CLK_NS = 4;
    localparam int RST_PULSE_NS = 1500;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] TOUT_CYC_0 = 13'h0010;
    localparam logic [CNT_W-1:0] TOUT_CYC_1 = 13'h0100;
    localparam logic [CNT_W-1:0] TOUT_CYC_2 = 13'h0400;
    localparam logic [CNT_W-1:0] TOUT_CYC_3 = 13'h1000;
    localparam int WDT_W = 24;
    localparam int WDT_TOUT_DEF = 16384;
    // ============
    // Reset sequencer states
    typedef enum logic [1:0] {RST_HOLD, RST_COUNT, RST_RUN} rspg_rst_e;
endpackage : rspg_pkg

// File: src/rspg_pin_filter.sv
// Two-stage synchroniser followed by a minimum-width filter.
// Assumes the pin is asynchronous to mclk and static fuses are not used here.
`timescale 1ns/10ps
module rspg_pin_filter #(
    parameter int unsigned MIN_CYC = 1,
    parameter bit ACT_LOW = 1'b0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Pin and filtered level
    input wire logic pin_a,
    output logic hit
);
    localparam int CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);

    logic [1:0] sync_ff;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic hit_ff;
    wire act = sync_ff[1] ^ ACT_LOW;

    // Count how long the level has been active; shorter spikes never reach the limit
    assign nxt_cnt = !act ? '0 : (cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 1'b1;
    assign hit = hit_ff;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync_ff <= {2{ACT_LOW}};
            cnt_ff <= '0;
            hit_ff <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[0], pin_a};
            cnt_ff <= nxt_cnt;
            hit_ff <= (nxt_cnt == CNT_MAX);
        end
    end
endmodule : rspg_pin_filter

// File: tb/rspg_top_asserts.sv
// Port checker of the reset and sleep power gating block.
// Assumes it is bound into rspg_top and shares its clock and reset.
`timescale 1ns/10ps
module rspg_top_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Sources and fuses
    input wire logic poweron_low,
    input wire logic brownout_low,
    input wire logic brownout_detect_fuse,
    input wire logic onchip_debug_fuse,
    input wire logic jtag_port_fuse,
    input wire logic [3:0] clock_select_fuses,
    // TAP
    input wire logic tap_shifting,
    input wire logic tap_tdo,
    input wire logic tdo_o,
    input wire logic tdo_oe,
    // Outputs under check
    input wire logic sys_reset,
    input wire logic io_port_reset,
    input wire logic adc_power,
    input wire logic ac_power,
    input wire logic bandgap_en,
    input wire logic brownout_power,
    input wire logic wdt_run,
    input wire logic in_buf_en,
    input wire logic main_clk_en,
    input wire logic jtag_en
);
    default clocking dck @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ============
    // Edges counted since the hold state ended
    logic [rspg_pkg::CNT_W-1:0] tout;
    logic [rspg_pkg::CNT_W-1:0] cnt_ff;
    logic [rspg_pkg::CNT_W-1:0] nxt_cnt;
    assign tout = clock_select_fuses[1] ? (clock_select_fuses[0] ? rspg_pkg::TOUT_CYC_3 : rspg_pkg::TOUT_CYC_2)
        : (clock_select_fuses[0] ? rspg_pkg::TOUT_CYC_1 : rspg_pkg::TOUT_CYC_0);
    assign nxt_cnt = io_port_reset ? '0 : cnt_ff + {{(rspg_pkg::CNT_W-1){1'b0}}, sys_reset};
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    // ============
    // Properties
    AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("no bus answer");
    AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    AST_POR_FORCE: assert property (poweron_low |-> sys_reset && io_port_reset)
        else $error("no power-on reset");
    AST_BOD_FORCE: assert property (brownout_detect_fuse && brownout_low |-> sys_reset && io_port_reset)
        else $error("no brown-out reset");
    AST_HOLD: assert property (io_port_reset |-> sys_reset)
        else $error("early release");
    AST_STRETCH: assert property ($fell(sys_reset) |-> cnt_ff >= tout - 1 && cnt_ff <= tout + 1)
        else $error("bad stretch");
    AST_REF_NEED: assert property (adc_power || brownout_power |-> bandgap_en)
        else $error("reference off");
    AST_BOD_ON: assert property (brownout_detect_fuse && !$past(reset) |-> brownout_power)
        else $error("detector off");
    AST_AC_DEEP: assert property (!in_buf_en |-> !ac_power)
        else $error("comparator on");
    AST_SLEEP_KEEP: assert property ($fell(in_buf_en) |-> $stable(adc_power) && $stable(wdt_run))
        else $error("sleep gated a unit");
    AST_DBG_CLK: assert property (onchip_debug_fuse && jtag_en |-> main_clk_en)
        else $error("main clock off");
    AST_JTAG_FUSE: assert property (!jtag_port_fuse |-> !jtag_en)
        else $error("port on");
    AST_TDO_OFF: assert property (!$past(tap_shifting) |-> !tdo_oe)
        else $error("TDO driven");
    AST_TDO_DATA: assert property (tdo_oe |-> jtag_en && tdo_o == $past(tap_tdo))
        else $error("TDO wrong");
endmodule : rspg_top_asserts

bind rspg_top rspg_top_asserts u_rspg_top_asserts (.*);

// File: tb/rspg_partner.sv
// Model of the supply detectors, the reset pin and the JTAG chain.
// Assumes level() is called right after a rising edge of mclk.
`timescale 1ns/10ps
module rspg_partner (
    // Clock
    input wire logic mclk,
    // Supply detectors and reset pin
    output logic poweron_low,
    output logic brownout_low,
    output logic ext_reset_n,
    // Scan chain and TAP
    output logic jtag_reset_reg,
    output logic tap_shifting,
    output logic tap_tdo
);
    initial begin
        poweron_low = 1'b0;
        brownout_low = 1'b0;
        ext_reset_n = 1'b1;
        jtag_reset_reg = 1'b0;
        tap_shifting = 1'b0;
        tap_tdo = 1'b0;
    end
    // Outside shifting TDO data flips each cycle, so stale data never looks valid
    always @(posedge mclk) begin
        tap_tdo <= tap_shifting | !tap_tdo;
    end
    task automatic level(input int sel, input logic v);
        @(posedge mclk);
        case (sel)
            0: poweron_low <= v;
            1: brownout_low <= v;
            2: ext_reset_n <= !v;
            3: jtag_reset_reg <= v;
            default: tap_shifting <= v;
        endcase
    endtask : level
endmodule : rspg_partner

// File: tb/rspg_top_tb.sv
// Self-checking bench of the reset and sleep power gating block.
// Assumes the partner model drives the detectors, reset pin and TAP.
`timescale 1ns/10ps
module rspg_top_tb;
    // ============
    // Signals
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rdat;
    logic avs_waitrequest, poweron_low, brownout_low, ext_reset_n, jtag_reset_reg, tap_shifting, tap_tdo;
    logic brownout_detect_fuse = 1'b0, brownout_level_fuse = 1'b0, onchip_debug_fuse = 1'b1, jtag_port_fuse = 1'b1;
    logic [3:0] clock_select_fuses = 4'h0;
    logic [1:0] startup_time_fuses = 2'h0;
    logic wake_a = 1'b0, adc_conv_done = 1'b0;
    logic tdo_o, tdo_oe, sys_reset, io_port_reset, adc_power, adc_ext_conv, ac_power, bandgap_en;
    logic brownout_power, brownout_level, wdt_run, in_buf_en, main_clk_en, jtag_en, deep, pd;
    logic [2:0] modes [6] = '{rspg_pkg::MODE_IDLE, rspg_pkg::MODE_ADCNR, rspg_pkg::MODE_PDOWN,
        rspg_pkg::MODE_PSAVE, rspg_pkg::MODE_STBY, rspg_pkg::MODE_XSTBY};
    int flag_at [4] = '{rspg_pkg::FL_POR, rspg_pkg::FL_BOD, rspg_pkg::FL_EXT, rspg_pkg::FL_JTAG};
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int i, j, k;
    localparam logic [3:0] CTL = rspg_pkg::OFS_CTRL;
    localparam logic [3:0] STA = rspg_pkg::OFS_STATUS;
    localparam logic [31:0] ADC = 32'h1 << rspg_pkg::CB_ADC_EN;
    localparam logic [31:0] AC = 32'h1 << rspg_pkg::CB_AC_EN;
    localparam logic [31:0] BG = 32'h1 << rspg_pkg::CB_AC_BG;
    localparam logic [31:0] WDT = 32'h1 << rspg_pkg::CB_WDT_EN;
    localparam logic [31:0] JOFF = 32'h1 << rspg_pkg::CB_JTAG_OFF;
    localparam logic [31:0] SLP = 32'h1 << rspg_pkg::CB_SLP_EN;
    rspg_top #(.WDT_TOUT_CYC(64)) u_rspg_top (.*);
    rspg_partner u_rspg_partner (.*);
    // ============
    // Clock and timeout
    initial begin
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ============
    // Tasks
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d = 32'h0);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk({31'h0, avs_waitrequest}, 32'h0000_0000);
    endtask : bus
    task automatic wait_rst(input logic v);
        int n;
        n = 0;
        while (sys_reset !== v && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, sys_reset}, {31'h0, v});
    endtask : wait_rst
    // ============
    // Main sequence
    initial begin
        tick(16);
        reset <= 1'b0;
        wait_rst(1'b0);
        bus(1'b0, CTL);
        chk(rdat, rspg_pkg::CTRL_RST);
        bus(1'b0, 4'h2);
        chk(rdat, 32'h0);
        bus(1'b1, CTL, ADC);
        tick(3);
        chk({29'h0, adc_power, bandgap_en, adc_ext_conv}, 32'h7);
        adc_conv_done <= 1'b1;
        tick(1);
        adc_conv_done <= 1'b0;
        tick(2);
        chk({31'h0, adc_ext_conv}, 32'h0);
        bus(1'b1, CTL);
        tick(3);
        chk({30'h0, adc_power, bandgap_en}, 32'h0);
        bus(1'b1, CTL, ADC);
        tick(3);
        chk({31'h0, adc_ext_conv}, 32'h1);
        bus(1'b1, CTL, AC | BG);
        tick(3);
        chk({30'h0, ac_power, bandgap_en}, 32'h3);
        // Each sleep mode, port on then off
        for (j = 0; j < 2; j++) begin
            for (i = 0; i < 6; i++) begin
                deep = modes[i] > rspg_pkg::MODE_ADCNR;
                pd = modes[i] == rspg_pkg::MODE_PDOWN || modes[i] == rspg_pkg::MODE_PSAVE;
                bus(1'b1, rspg_pkg::OFS_WDT, 32'h1);
                bus(1'b1, CTL, ADC | AC | WDT | SLP | ({29'h0, modes[i]} << rspg_pkg::CB_MODE_LO)
                    | (j == 1 ? JOFF : 32'h0));
                bus(1'b1, rspg_pkg::OFS_SLEEP, 32'h1);
                tick(3);
                chk({26'h0, adc_power, wdt_run, ac_power, in_buf_en, main_clk_en, jtag_en},
                    {26'h0, 2'b11, !deep, !deep, !(pd && j == 1), j == 0});
                wake_a <= 1'b1;
                tick(4);
                wake_a <= 1'b0;
                tick(4);
            end
        end
        bus(1'b1, CTL);
        u_rspg_partner.level(4, 1'b1);
        tick(4);
        chk({30'h0, tdo_oe, tdo_o}, 32'h3);
        u_rspg_partner.level(4, 1'b0);
        tick(3);
        chk({31'h0, tdo_oe}, 32'h0);
        bus(1'b1, CTL, WDT);
        tick(3);
        chk({31'h0, wdt_run}, 32'h1);
        wait_rst(1'b1);
        wait_rst(1'b0);
        bus(1'b0, STA);
        chk({30'h0, wdt_run, rdat[rspg_pkg::FL_WDT]}, 32'h1);
        u_rspg_partner.level(2, 1'b1);
        tick(100);
        u_rspg_partner.level(2, 1'b0);
        u_rspg_partner.level(1, 1'b1);
        tick(10);
        chk({31'h0, sys_reset}, 32'h0);
        u_rspg_partner.level(1, 1'b0);
        reset <= 1'b1;
        brownout_detect_fuse <= 1'b1;
        tick(16);
        reset <= 1'b0;
        wait_rst(1'b0);
        chk({29'h0, brownout_power, brownout_level, bandgap_en}, 32'h5);
        bus(1'b1, STA);
        for (k = 0; k < 4; k++) begin
            u_rspg_partner.level(k, 1'b1);
            tick(420);
            chk({30'h0, sys_reset, io_port_reset}, 32'h3);
            u_rspg_partner.level(k, 1'b0);
            wait_rst(1'b0);
            bus(1'b0, STA);
            chk({31'h0, rdat[flag_at[k]]}, 32'h1);
            bus(1'b1, STA);
        end
        reset <= 1'b1;
        jtag_port_fuse <= 1'b0;
        tick(16);
        reset <= 1'b0;
        wait_rst(1'b0);
        u_rspg_partner.level(4, 1'b1);
        tick(4);
        chk({30'h0, jtag_en, tdo_oe}, 32'h0);
        u_rspg_partner.level(4, 1'b0);
        tally_and_finish();
    end
endmodule : rspg_top_tb
